// file: pkg/hpa_defines.svh
`ifndef HPA_DEFINES_SVH
`define HPA_DEFINES_SVH

// Command opcodes
`define HPA_OP_RD_NATIVE     8'hf8
`define HPA_OP_RD_NATIVE_EXT 8'h27
`define HPA_OP_SET_MAX       8'hf9
`define HPA_OP_SET_MAX_EXT   8'h37

// Set Max subcommands in the feature field
`define HPA_FT_ADDR          8'h00
`define HPA_FT_SET_PW        8'h01
`define HPA_FT_LOCK          8'h02
`define HPA_FT_UNLOCK        8'h03
`define HPA_FT_FREEZE        8'h04

// Widths
`define HPA_LBA_W            48
`define HPA_LBA28_W          28
`define HPA_PW_W             32
`define HPA_ID_W             16
`define HPA_CNT_W            17

// Address limits and identify fields
`define HPA_LBA28_MAX        48'h0000_0fff_ffff
`define HPA_NATIVE_MAX       48'h0000_00c1_acff
`define HPA_ID_EXT_BIT       8

`endif

// file: pkg/hpa_pkg.sv
`include "hpa_defines.svh"

package hpa_pkg;

   typedef struct packed {
      logic [7:0]              opcode;
      logic [7:0]              feature;
      logic [`HPA_LBA_W-1:0]   lba;
      logic                    volat;
      logic [`HPA_PW_W-1:0]    pw;
   } hpa_cmd_t;

   typedef struct packed {
      logic                    abort;
      logic [`HPA_LBA_W-1:0]   lba;
   } hpa_rsp_t;

   typedef struct packed {
      logic [`HPA_ID_W-1:0]    w83;
      logic [`HPA_ID_W-1:0]    w86;
      logic [`HPA_LBA_W-1:0]   max48;
      logic [`HPA_LBA28_W-1:0] cap28;
   } hpa_ident_t;

   typedef struct packed {
      logic set_pw;
      logic lock;
      logic unlock;
      logic freeze;
   } hpa_lock_ev_t;

   typedef enum logic [2:0] {
      HPA_OPEN  = 3'b001,
      HPA_GUARD = 3'b010,
      HPA_SEAL  = 3'b100
   } hpa_lock_t;

endpackage

// file: verilog/hpa_lock_fsm.sv
`timescale 1ns/1ps
`default_nettype none

module hpa_lock_fsm
   import hpa_pkg::*;
(
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   // Accepted events
   input  wire hpa_lock_ev_t ev,
   // State
   output var  hpa_lock_t    st_q,
   output var  logic         pw_set_q
);

   hpa_lock_t st_d;
   logic      pw_set_d;

   always_comb begin
      st_d     = st_q;
      pw_set_d = pw_set_q;
      unique case (st_q)
         HPA_OPEN: begin
            if (ev.set_pw) begin
               pw_set_d = 1'b1;
               st_d     = HPA_OPEN;
            end else if (ev.lock) begin
               st_d = HPA_GUARD;
            end else if (ev.freeze) begin
               st_d = HPA_SEAL;
            end
         end
         HPA_GUARD: begin
            if (ev.unlock) begin
               st_d = HPA_OPEN;
            end
         end
         HPA_SEAL: begin
            st_d = HPA_SEAL;
         end
         default: begin
            st_d = HPA_OPEN;
         end
      endcase
   end

   // Only power-on reset clears the lock state
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         st_q     <= HPA_OPEN;
         pw_set_q <= 1'b0;
      end else if (ce) begin
         st_q     <= st_d;
         pw_set_q <= pw_set_d;
      end
   end

   seal_sticky_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_q == HPA_SEAL |=> st_q == HPA_SEAL)
      else $error("sealed mode left");

   guard_hold_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      st_q == HPA_GUARD && !(ce && ev.unlock) |=> st_q == HPA_GUARD)
      else $error("guarded mode left without unlock");

endmodule

`default_nettype wire

// file: verilog/hpa_range_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defines.svh"

module hpa_range_chk #(
   parameter int W  = `HPA_LBA_W,
   parameter int CW = `HPA_CNT_W
) (
   // Clock and reset
   input  wire logic         clk,
   input  wire logic         sys_rst,
   input  wire logic         ce,
   // Request
   input  wire logic         req_valid,
   input  wire logic [W-1:0] lba,
   input  wire logic [CW-1:0] cnt,
   input  wire logic [W-1:0] max_lba,
   // Result
   output var  logic         done_q,
   output var  logic         ok_q
);

   logic [W:0] last;
   logic       done_d;
   logic       ok_d;

   always_comb begin
      last   = {1'b0, lba} + {{(W+1-CW){1'b0}}, cnt} - {{W{1'b0}}, 1'b1};
      done_d = req_valid;
      ok_d   = ok_q;
      if (req_valid) begin
         if (cnt == '0) begin
            ok_d = lba <= max_lba;
         end else begin
            ok_d = last <= {1'b0, max_lba};
         end
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         done_q <= 1'b0;
         ok_q   <= 1'b0;
      end else if (ce) begin
         done_q <= done_d;
         ok_q   <= ok_d;
      end
   end

   beyond_max_a: assert property (
      @(posedge clk) disable iff (sys_rst)
      ce && req_valid && lba > max_lba |=> done_q && !ok_q)
      else $error("access above max allowed");

endmodule

`default_nettype wire

// file: verilog/hpa_guard.sv
// How it works
// - Read native returns native maximum, clamped to 28 bits
// - Set max applies volatile or nonvolatile
// - Blocks above maximum are refused
// - Reduced device looks like smaller device
// - Volatile maximum dropped on hard reset
// - Password kept until power cycle only
// - Password separate from security feature
// - Setting password enters open mode
// - Lock enters guarded, blocks set max except unlock
// - Unlock returns guarded to open mode
// - Freeze enters sealed, blocks every set max command
// - Identify words report extension support
// - Opcode 27h reads 48-bit native maximum
// - Identify capacity follows configured maximum
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defines.svh"

module hpa_guard
   import hpa_pkg::*;
#(
   parameter logic [`HPA_LBA_W-1:0] NATIVE_MAX = `HPA_NATIVE_MAX
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   sys_rst,
   input  wire logic                   ce,
   // Device resets
   input  wire logic                   hard_rst,
   input  wire logic                   soft_rst,
   // Nonvolatile limit store
   input  wire logic [`HPA_LBA_W-1:0]  nv_max,
   output var  logic                   nv_wr_q,
   output var  logic [`HPA_LBA_W-1:0]  nv_wr_lba_q,
   // Command and response
   input  wire logic                   cmd_valid,
   input  wire hpa_cmd_t               cmd,
   output var  logic                   rsp_valid_q,
   output var  hpa_rsp_t               rsp_q,
   // Media access check
   input  wire logic                   acc_valid,
   input  wire logic [`HPA_LBA_W-1:0]  acc_lba,
   input  wire logic [`HPA_CNT_W-1:0]  acc_cnt,
   output var  logic                   acc_done_q,
   output var  logic                   acc_ok_q,
   // Identify and status
   output var  hpa_ident_t             ident_q,
   output var  hpa_lock_t              lock_st_q,
   output var  logic                   pw_set_q
);

   function automatic logic [`HPA_LBA_W-1:0] clamp28(
      input logic [`HPA_LBA_W-1:0] v);
      clamp28 = (v > `HPA_LBA28_MAX) ? `HPA_LBA28_MAX : v;
   endfunction

   logic                   ld_pend_q;
   logic                   ld_pend_d;
   logic [`HPA_LBA_W-1:0]  cur_max_q;
   logic [`HPA_LBA_W-1:0]  cur_max_d;
   logic [`HPA_LBA_W-1:0]  nv_lim_q;
   logic [`HPA_LBA_W-1:0]  nv_lim_d;
   logic [`HPA_PW_W-1:0]   pw_q;
   logic [`HPA_PW_W-1:0]   pw_d;
   logic                   nv_wr_d;
   logic [`HPA_LBA_W-1:0]  nv_wr_lba_d;
   logic                   rsp_valid_d;
   hpa_rsp_t               rsp_d;
   hpa_ident_t             ident_d;
   hpa_lock_ev_t           ev;
   logic                   fire;
   logic                   is_rn;
   logic                   is_rne;
   logic                   is_sm;
   logic                   is_sec;
   logic                   is_open;
   logic [`HPA_LBA_W-1:0]  new_max;
   logic                   sm_ok;
   logic [`HPA_LBA_W-1:0]  cap_v;

   // Command decode
   always_comb begin
      fire   = ce && cmd_valid && !ld_pend_q && !hard_rst;
      is_rn  = cmd.opcode == `HPA_OP_RD_NATIVE;
      is_rne = cmd.opcode == `HPA_OP_RD_NATIVE_EXT;
      is_sec = cmd.opcode == `HPA_OP_SET_MAX
               && cmd.feature != `HPA_FT_ADDR;
      is_sm  = cmd.opcode == `HPA_OP_SET_MAX_EXT
               || (cmd.opcode == `HPA_OP_SET_MAX
                   && cmd.feature == `HPA_FT_ADDR);
      is_open = lock_st_q == HPA_OPEN;
      if (cmd.opcode == `HPA_OP_SET_MAX_EXT) begin
         new_max = cmd.lba;
      end else begin
         new_max = {{(`HPA_LBA_W-`HPA_LBA28_W){1'b0}},
                    cmd.lba[`HPA_LBA28_W-1:0]};
      end
      sm_ok = fire && is_sm && is_open
              && new_max <= NATIVE_MAX;
   end

   // Lock events, each gated by the current mode
   always_comb begin
      ev        = '0;
      ev.set_pw = fire && is_sec && is_open
                  && cmd.feature == `HPA_FT_SET_PW;
      ev.lock   = fire && is_sec && is_open && pw_set_q
                  && cmd.feature == `HPA_FT_LOCK;
      ev.unlock = fire && is_sec && lock_st_q == HPA_GUARD
                  && cmd.feature == `HPA_FT_UNLOCK
                  && cmd.pw == pw_q;
      ev.freeze = fire && is_sec && is_open
                  && cmd.feature == `HPA_FT_FREEZE;
   end

   // Response
   always_comb begin
      rsp_valid_d = fire;
      rsp_d       = rsp_q;
      if (fire) begin
         rsp_d.abort = 1'b1;
         rsp_d.lba   = '0;
         if (is_rne) begin
            rsp_d.abort = 1'b0;
            rsp_d.lba   = NATIVE_MAX;
         end else if (is_rn) begin
            rsp_d.abort = 1'b0;
            rsp_d.lba   = clamp28(NATIVE_MAX);
         end else if (sm_ok) begin
            rsp_d.abort = 1'b0;
            rsp_d.lba   = new_max;
         end else if (ev != '0) begin
            rsp_d.abort = 1'b0;
         end
      end
   end

   // Limits and password
   always_comb begin
      ld_pend_d   = 1'b0;
      cur_max_d   = cur_max_q;
      nv_lim_d    = nv_lim_q;
      pw_d        = pw_q;
      nv_wr_d     = 1'b0;
      nv_wr_lba_d = nv_wr_lba_q;
      if (ld_pend_q) begin
         cur_max_d = nv_max;
         nv_lim_d  = nv_max;
      end else if (hard_rst) begin
         cur_max_d = nv_lim_q;
      end else if (sm_ok) begin
         cur_max_d = new_max;
         if (!cmd.volat) begin
            nv_lim_d    = new_max;
            nv_wr_d     = 1'b1;
            nv_wr_lba_d = new_max;
         end
      end
      if (ev.set_pw) begin
         pw_d = cmd.pw;
      end
   end

   // Identify fields
   always_comb begin
      ident_d       = '0;
      cap_v         = clamp28(cur_max_q + {{(`HPA_LBA_W-1){1'b0}}, 1'b1});
      ident_d.w83[`HPA_ID_EXT_BIT] = 1'b1;
      ident_d.w86[`HPA_ID_EXT_BIT] = pw_set_q;
      ident_d.max48 = cur_max_q;
      ident_d.cap28 = cap_v[`HPA_LBA28_W-1:0];
   end

   // Soft and hard reset leave the password alone
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         ld_pend_q   <= 1'b1;
         cur_max_q   <= '0;
         nv_lim_q    <= '0;
         pw_q        <= '0;
         nv_wr_q     <= 1'b0;
         nv_wr_lba_q <= '0;
         rsp_valid_q <= 1'b0;
         rsp_q       <= '0;
         ident_q     <= '0;
      end else if (ce) begin
         ld_pend_q   <= ld_pend_d;
         cur_max_q   <= cur_max_d;
         nv_lim_q    <= nv_lim_d;
         pw_q        <= pw_d;
         nv_wr_q     <= nv_wr_d;
         nv_wr_lba_q <= nv_wr_lba_d;
         rsp_valid_q <= rsp_valid_d;
         rsp_q       <= rsp_d;
         ident_q     <= ident_d;
      end
   end

   hpa_lock_fsm u_lock (
      .clk      (clk),
      .sys_rst  (sys_rst),
      .ce       (ce),
      .ev       (ev),
      .st_q     (lock_st_q),
      .pw_set_q (pw_set_q)
   );

   hpa_range_chk #(
      .W  (`HPA_LBA_W),
      .CW (`HPA_CNT_W)
   ) u_range (
      .clk       (clk),
      .sys_rst   (sys_rst),
      .ce        (ce),
      .req_valid (acc_valid),
      .lba       (acc_lba),
      .cnt       (acc_cnt),
      .max_lba   (cur_max_q),
      .done_q    (acc_done_q),
      .ok_q      (acc_ok_q)
   );

   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence sm_taken;
      sm_ok ##1 rsp_valid_q && !rsp_q.abort;
   endsequence

   native_ext_a: assert property (
      fire && is_rne |=> rsp_valid_q && !rsp_q.abort
                         && rsp_q.lba == NATIVE_MAX)
      else $error("native ext read wrong");

   native_28_a: assert property (
      fire && is_rn |=> !rsp_q.abort
                        && rsp_q.lba <= `HPA_LBA28_MAX
                        && rsp_q.lba <= NATIVE_MAX)
      else $error("native read wrong");

   set_apply_a: assert property (
      sm_ok ##0 sm_taken |-> cur_max_q == $past(new_max))
      else $error("set max not applied");

   nv_store_a: assert property (
      sm_ok && !cmd.volat |=> nv_wr_q && nv_wr_lba_q == $past(new_max))
      else $error("nonvolatile value not stored");

   hard_drop_a: assert property (
      ce && hard_rst && !ld_pend_q |=> cur_max_q == $past(nv_lim_q))
      else $error("volatile max survived hard reset");

   blocked_cmd_a: assert property (
      fire && is_sm && !is_open
      |=> rsp_q.abort && $stable(cur_max_q))
      else $error("blocked set max changed state");

   pw_keep_a: assert property (
      pw_set_q |=> pw_set_q && (pw_q == $past(pw_q) || $past(ev.set_pw)))
      else $error("password lost without power cycle");

   ident_cap_a: assert property (
      ce ##1 ce |-> ident_q.max48 == $past(cur_max_q)
                   && ident_q.w83[`HPA_ID_EXT_BIT])
      else $error("identify capacity stale");

   pw_open_a: assert property (
      ev.set_pw |=> pw_set_q && lock_st_q == HPA_OPEN)
      else $error("password set but mode not open");

   lock_guard_a: assert property (
      ev.lock |=> lock_st_q == HPA_GUARD)
      else $error("lock accepted but not guarded");

   unlock_open_a: assert property (
      ev.unlock |=> lock_st_q == HPA_OPEN)
      else $error("unlock accepted but not open");

   freeze_seal_a: assert property (
      ev.freeze |=> lock_st_q == HPA_SEAL)
      else $error("freeze accepted but not sealed");

   seal_abort_a: assert property (
      fire && lock_st_q == HPA_SEAL && !is_rn && !is_rne |=> rsp_q.abort)
      else $error("set max command taken while sealed");

   pw_sep_a: assert property (
      !ev.set_pw |=> $stable(pw_q))
      else $error("password changed without set password");

   ident_pw_a: assert property (
      ce ##1 ce |-> ident_q.w86[`HPA_ID_EXT_BIT] == $past(pw_set_q))
      else $error("identify enable flag stale");

   nv_load_a: assert property (
      ce && ld_pend_q |=> cur_max_q == $past(nv_max)
                          && nv_lim_q == $past(nv_max))
      else $error("stored limit not loaded after power up");

   soft_keep_a: assert property (
      soft_rst && ev == '0 |=> $stable(lock_st_q) && $stable(pw_q))
      else $error("soft reset disturbed lock state");

endmodule

`default_nettype wire

// file: verification/hpa_host_model.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defines.svh"

module hpa_host_model
   import hpa_pkg::*;
#(
   parameter logic [`HPA_LBA_W-1:0] NV_INIT = 48'h0000_00bb_85ff
) (
   // Clock
   input  wire logic                  clk,
   // Nonvolatile store
   input  wire logic                  nv_wr_q,
   input  wire logic [`HPA_LBA_W-1:0] nv_wr_lba_q,
   output var  logic [`HPA_LBA_W-1:0] nv_max,
   // Command side
   output var  logic                  cmd_valid,
   output var  hpa_cmd_t              cmd
);
   initial begin
      nv_max    = NV_INIT;
      cmd_valid = 1'b0;
      cmd       = '0;
   end

   // Store keeps what the device asks to save
   always @(posedge clk) begin
      if (nv_wr_q === 1'b1) begin
         nv_max <= nv_wr_lba_q;
      end
   end

   // One-cycle strobe; released fields are scrambled
   task automatic issue(input logic [7:0] op, input logic [7:0] ft,
                        input logic [47:0] lba, input logic vol,
                        input logic [31:0] pw);
      @(negedge clk);
      cmd_valid = 1'b1;
      cmd       = '{op, ft, lba, vol, pw};
      @(negedge clk);
      cmd_valid = 1'b0;
      cmd       = ~cmd;
   endtask
endmodule

`default_nettype wire

// file: verification/tb.sv
`timescale 1ns/1ps
`default_nettype none
`include "hpa_defines.svh"

module tb
   import hpa_pkg::*;
;
   localparam logic [47:0] NAT = `HPA_NATIVE_MAX;
   localparam logic [47:0] NV0 = 48'h0000_00bb_85ff;
   localparam logic [31:0] PW  = 32'h5a3c_96e1;
   logic        clk, sys_rst, ce, hard_rst, soft_rst, acc_valid;
   logic        nv_wr_q, cmd_valid, rsp_valid_q, acc_done_q, acc_ok_q;
   logic        pw_set_q;
   logic [47:0] nv_max, nv_wr_lba_q, acc_lba, v;
   logic [16:0] acc_cnt;
   logic [31:0] lfsr;
   hpa_cmd_t    cmd;
   hpa_rsp_t    rsp_q;
   hpa_ident_t  ident_q;
   hpa_lock_t   lock_st_q;
   hpa_rsp_t    rsp_exp[$];
   logic        lba_chk[$];
   logic        acc_exp[$];
   int          failures;
   int          cmp_count;

   hpa_host_model #(.NV_INIT(NV0)) u_hpa_host_model (
      .clk(clk), .nv_wr_q(nv_wr_q), .nv_wr_lba_q(nv_wr_lba_q),
      .nv_max(nv_max), .cmd_valid(cmd_valid), .cmd(cmd));

   hpa_guard #(.NATIVE_MAX(NAT)) u_hpa_guard (
      .clk(clk), .sys_rst(sys_rst), .ce(ce), .hard_rst(hard_rst),
      .soft_rst(soft_rst), .nv_max(nv_max), .nv_wr_q(nv_wr_q),
      .nv_wr_lba_q(nv_wr_lba_q), .cmd_valid(cmd_valid), .cmd(cmd),
      .rsp_valid_q(rsp_valid_q), .rsp_q(rsp_q), .acc_valid(acc_valid),
      .acc_lba(acc_lba), .acc_cnt(acc_cnt), .acc_done_q(acc_done_q),
      .acc_ok_q(acc_ok_q), .ident_q(ident_q), .lock_st_q(lock_st_q),
      .pw_set_q(pw_set_q));

   initial clk = 1'b0;
   always #25 clk = ~clk;

   function automatic logic [31:0] lfsr_next(input logic [31:0] s);
      lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   task automatic chk_val(input string what, input logic [47:0] e,
                          input logic [47:0] g);
      cmp_count++;
      if (g !== e) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, e, g);
      end
   endtask

   task automatic chk_rsp(input hpa_rsp_t e, input logic lc,
                          input hpa_rsp_t g);
      chk_val("rsp_abort", 48'(e.abort), 48'(g.abort));
      if (lc) chk_val("rsp_lba", e.lba, g.lba);
   endtask

   // Result watcher pairs outputs with the oldest note
   always @(negedge clk) begin
      if (rsp_valid_q === 1'b1) begin
         if (rsp_exp.size() == 0) chk_val("rsp_extra", 48'h0, 48'h1);
         else chk_rsp(rsp_exp.pop_front(), lba_chk.pop_front(), rsp_q);
      end
      if (acc_done_q === 1'b1) begin
         if (acc_exp.size() == 0) chk_val("acc_extra", 48'h0, 48'h1);
         else chk_val("acc_ok", 48'(acc_exp.pop_front()), 48'(acc_ok_q));
      end
   end

   task automatic send(input logic [7:0] op, input logic [7:0] ft,
                       input logic [47:0] lba, input logic vol,
                       input logic [31:0] pw, input logic ab,
                       input logic lc, input logic [47:0] el);
      rsp_exp.push_back('{ab, el});
      lba_chk.push_back(lc);
      u_hpa_host_model.issue(op, ft, lba, vol, pw);
   endtask

   task automatic acc(input logic [47:0] l, input logic [16:0] c,
                      input logic ok);
      acc_exp.push_back(ok);
      @(negedge clk);
      acc_valid = 1'b1;
      acc_lba   = l;
      acc_cnt   = c;
      @(negedge clk);
      acc_valid = 1'b0;
      acc_lba   = ~l;
      acc_cnt   = ~c;
   endtask

   task automatic pulse(input logic hard);
      @(negedge clk);
      if (hard) hard_rst = 1'b1;
      else soft_rst = 1'b1;
      @(negedge clk);
      hard_rst = 1'b0;
      soft_rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic do_reset();
      sys_rst = 1'b1;
      repeat (3) @(negedge clk);
      sys_rst = 1'b0;
      repeat (2) @(negedge clk);
   endtask

   task automatic chk_mode(input hpa_lock_t m, input logic p);
      @(negedge clk);
      chk_val("lock_st", 48'(m), 48'(lock_st_q));
      chk_val("pw_set", 48'(p), 48'(pw_set_q));
      chk_val("w86", p ? 48'h100 : 48'h0, 48'(ident_q.w86));
   endtask

   task automatic summarize();
      if (rsp_exp.size() != 0 || acc_exp.size() != 0) failures++;
      $display("Comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk);
      chk_val("watchdog", 48'h0, 48'h1);
      summarize();
   end

   initial begin
      sys_rst = 1'b1; ce = 1'b1; hard_rst = 1'b0; soft_rst = 1'b0;
      acc_valid = 1'b0; acc_lba = '0; acc_cnt = '0; lfsr = 32'h35e8;
      failures = 0; cmp_count = 0; v = NV0;
      do_reset();
      chk_val("w83", 48'h100, 48'(ident_q.w83));
      chk_mode(HPA_OPEN, 1'b0);
      chk_val("max48", NV0, ident_q.max48);
      send(`HPA_OP_RD_NATIVE_EXT, 0, 0, 0, 0, 0, 1, NAT);
      send(`HPA_OP_RD_NATIVE, 0, 0, 0, 0, 0, 1, NAT);
      acc(NV0, 1, 1);
      acc(NV0, 2, 0);
      acc(NV0 + 1, 0, 0);
      acc(0, 17'h1ffff, 1);
      send(`HPA_OP_SET_MAX, `HPA_FT_ADDR, NAT, 1, 0, 0, 1, NAT);
      @(negedge clk);
      chk_val("max48", NAT, ident_q.max48);
      chk_val("cap28", 48'(28'(NAT + 1)), 48'(ident_q.cap28));
      chk_val("nv_kept", NV0, nv_max);
      acc(NAT, 1, 1);
      acc(NAT, 2, 0);
      pulse(1'b0);
      chk_val("max48", NAT, ident_q.max48);
      pulse(1'b1);
      chk_val("max48", NV0, ident_q.max48);
      acc(NV0 + 1, 0, 0);
      repeat (4) begin
         lfsr = lfsr_next(lfsr);
         v = {24'h0, lfsr[23:0]};
         if (v > NAT) v = v - NAT;
         send(`HPA_OP_SET_MAX_EXT, `HPA_FT_ADDR, v, 0, 0, 0, 1, v);
         @(negedge clk);
         chk_val("nv_saved", v, nv_max);
         chk_val("max48", v, ident_q.max48);
         acc(v, 1, 1);
         acc(v + 1, 0, 0);
      end
      send(`HPA_OP_SET_MAX_EXT, 0, NAT + 1, 0, 0, 1, 0, 0);
      pulse(1'b1);
      chk_val("max48", v, ident_q.max48);
      @(negedge clk) ce = 1'b0;
      u_hpa_host_model.issue(`HPA_OP_SET_MAX_EXT, 8'h00, NAT, 1'b1, 32'h0);
      @(negedge clk) ce = 1'b1;
      repeat (2) @(negedge clk);
      chk_val("max48_frozen", v, ident_q.max48);
      send(`HPA_OP_SET_MAX, `HPA_FT_LOCK, 0, 0, 0, 1, 0, 0);
      send(`HPA_OP_SET_MAX, `HPA_FT_SET_PW, 0, 0, PW, 0, 0, 0);
      chk_mode(HPA_OPEN, 1'b1);
      pulse(1'b0);
      pulse(1'b1);
      chk_mode(HPA_OPEN, 1'b1);
      send(`HPA_OP_SET_MAX, `HPA_FT_LOCK, 0, 0, 0, 0, 0, 0);
      chk_mode(HPA_GUARD, 1'b1);
      send(`HPA_OP_SET_MAX, `HPA_FT_ADDR, NAT, 1, 0, 1, 0, 0);
      send(`HPA_OP_SET_MAX, `HPA_FT_FREEZE, 0, 0, 0, 1, 0, 0);
      send(`HPA_OP_SET_MAX, `HPA_FT_UNLOCK, 0, 0, ~PW, 1, 0, 0);
      chk_mode(HPA_GUARD, 1'b1);
      chk_val("max48", v, ident_q.max48);
      send(`HPA_OP_SET_MAX, `HPA_FT_UNLOCK, 0, 0, PW, 0, 0, 0);
      chk_mode(HPA_OPEN, 1'b1);
      send(`HPA_OP_SET_MAX, `HPA_FT_FREEZE, 0, 0, 0, 0, 0, 0);
      chk_mode(HPA_SEAL, 1'b1);
      send(`HPA_OP_SET_MAX, `HPA_FT_UNLOCK, 0, 0, PW, 1, 0, 0);
      send(`HPA_OP_SET_MAX, `HPA_FT_SET_PW, 0, 0, PW, 1, 0, 0);
      send(`HPA_OP_SET_MAX_EXT, 0, NAT, 1, 0, 1, 0, 0);
      pulse(1'b1);
      chk_mode(HPA_SEAL, 1'b1);
      chk_val("max48", v, ident_q.max48);
      do_reset();
      chk_mode(HPA_OPEN, 1'b0);
      chk_val("max48", v, ident_q.max48);
      repeat (2) @(negedge clk);
      summarize();
   end
endmodule

`default_nettype wire
